/* design/sfr_bank0.sv */
/*
  Bank-0 special function register file with plain read/write port.
  Assumes the core drives one-cycle strobes and a peripheral reset pulse
  (power-on or other) synchronous to i_mclk.
*/
// Function
// RQ1: Unimplemented addresses read zero, ignore writes
// RQ2: No-converter variant hides converter registers
// RQ3: Software keeps reserved converter flag bits zero
// RQ4: Software keeps converter control bit1 clear
// RQ5: Power-on and other resets load listed values
// RQ6: Unchanged bits keep, conditional bits follow cause
// RQ7: Port A resets and reads per variant
// RQ8: Registers are static storage cells
// RQ9: Indirect location redirects through pointer register
module sfr_bank0
  import sfr_pkg::*;
#(
  parameter bit HAS_CONVERTER = 1'b1
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Reset cause pulse from the reset controller
  input wire logic i_por_pulse,
  input wire logic i_other_rst_pulse,
  // Status bits 4:3 to load on a non-power-on reset
  input wire logic [1:0] i_status_cond,
  // Register port
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Indirect redirection toward data memory
  output logic o_ind_wr,
  output logic o_ind_rd,
  output logic [7:0] o_ind_addr,
  output logic [7:0] o_ind_wdata,
  input wire logic [7:0] i_ind_rdata,
  // Pin levels for read-only ports
  input wire logic [7:0] i_port_e_pins
);

  ////////////////////////////////////////////////////////////////////////
  // Storage
  logic [7:0] cell_reg [SFR_NUM]; // Static cells indexed by file address [RQ8]
  logic rd_ind_reg; // Read of the previous cycle was indirect
  logic [7:0] rdata_direct_reg; // Directly decoded read value
  sfr_rst_t rst_kind; // Reset applied this cycle

  ////////////////////////////////////////////////////////////////////////
  // Implemented mask per address
  function automatic logic [7:0] impl_mask(input logic [4:0] a);
    logic [7:0] m;
    m = SFR_ZERO;
    case (a)
      SFR_TIMER0, SFR_PCL, SFR_STATUS, SFR_POINTER, SFR_PORT_B, SFR_PORT_D,
      SFR_PORT_E, SFR_INTERRUPT_CONTROL, SFR_T1L, SFR_T1H, SFR_TIMER2, SFR_SERBUF,
      SFR_SERCON, SFR_CCL, SFR_CCH: m = SFR_MASK_ALL;
      SFR_PORT_A, SFR_PORT_C, SFR_TIMER1_CONTROL, SFR_CCCON: m = SFR_MASK_6;
      SFR_PROG_COUNTER_HIGH_LATCH: m = SFR_MASK_5;
      SFR_TIMER2_CONTROL: m = SFR_MASK_7;
      SFR_PIRQ: m = SFR_MASK_PIRQ;
      // Converter registers exist only on one variant
      SFR_CONV_RESULT, SFR_CONV_CTRL0: m = HAS_CONVERTER ? SFR_MASK_ALL : SFR_ZERO; // [RQ2]
      default: m = SFR_ZERO; // Gaps and indirect location hold nothing [RQ1] [RQ9]
    endcase
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Power-on value per address; unknown bits taken as zero
  function automatic logic [7:0] por_value(input logic [4:0] a);
    logic [7:0] v;
    v = SFR_ZERO;
    if (a == SFR_STATUS) begin
      v = SFR_STATUS_POR; // [RQ5]
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Addresses that load zero on a non-power-on reset
  function automatic logic zero_on_other(input logic [4:0] a);
    logic z;
    z = 1'b0;
    case (a)
      SFR_PCL, SFR_PORT_D, SFR_PORT_E, SFR_PROG_COUNTER_HIGH_LATCH, SFR_PIRQ, SFR_TIMER2,
      SFR_TIMER2_CONTROL, SFR_SERCON, SFR_CCCON, SFR_CONV_CTRL0: z = 1'b1; // [RQ5]
      default: z = 1'b0; // Others keep their contents; status is loaded separately below [RQ6]
    endcase
    return z;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset cause decode; power-on wins
  always_comb begin
    if (i_por_pulse) begin
      rst_kind = SFR_RST_POR;
    end else if (i_other_rst_pulse) begin
      rst_kind = SFR_RST_OTHER;
    end else begin
      rst_kind = SFR_RST_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register cells
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < SFR_NUM; i++) begin
        cell_reg[i] <= SFR_ZERO;
      end
      cell_reg[SFR_STATUS] <= SFR_STATUS_POR; // [RQ5]
    end else begin
      case (rst_kind)
        SFR_RST_POR: begin
          for (int i = 0; i < SFR_NUM; i++) begin
            cell_reg[i] <= por_value(5'(i)) & impl_mask(5'(i)); // [RQ5]
          end
        end
        SFR_RST_OTHER: begin
          for (int i = 0; i < SFR_NUM; i++) begin
            if (zero_on_other(5'(i))) begin
              cell_reg[i] <= SFR_ZERO; // [RQ5]
            end
          end
          // Upper status bits clear, conditional bits by cause, low bits kept
          cell_reg[SFR_STATUS] <= (cell_reg[SFR_STATUS] & SFR_STATUS_KEEP)
            | ({3'h0, i_status_cond, 3'h0} & SFR_STATUS_COND); // [RQ6]
          // Timer1 control keeps only on all other resets
          cell_reg[SFR_TIMER1_CONTROL] <= cell_reg[SFR_TIMER1_CONTROL]; // [RQ6]
        end
        default: begin
          // Read-only pins sample every cycle that has no reset pulse
          cell_reg[SFR_PORT_E] <= i_port_e_pins;
          // Writes go only to implemented bits of direct cells
          if (i_wr && (i_addr != SFR_PORT_E) && (i_addr != SFR_CONV_RESULT)) begin
            cell_reg[i_addr] <= i_wdata & impl_mask(i_addr); // [RQ1] [RQ3] [RQ4]
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Direct read data, registered one cycle after the strobe
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_direct_reg <= SFR_ZERO;
      rd_ind_reg <= 1'b0;
    end else begin
      rd_ind_reg <= i_rd && (i_addr == SFR_INDIRECT_DATA); // [RQ9]
      if (i_rd) begin
        if (i_addr == SFR_PORT_A && HAS_CONVERTER) begin
          // Analog-shared pins read zero on the converter variant
          rdata_direct_reg <= cell_reg[i_addr] & impl_mask(i_addr)
            & ~SFR_PORT_A_DATA_ANALOG; // [RQ7]
        end else begin
          rdata_direct_reg <= cell_reg[i_addr] & impl_mask(i_addr); // [RQ1] [RQ2]
        end
      end else begin
        rdata_direct_reg <= SFR_ZERO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Indirect redirection strobes toward data memory
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ind_wr <= 1'b0;
      o_ind_rd <= 1'b0;
      o_ind_addr <= SFR_ZERO;
      o_ind_wdata <= SFR_ZERO;
    end else begin
      o_ind_wr <= i_wr && (i_addr == SFR_INDIRECT_DATA); // [RQ9]
      o_ind_rd <= i_rd && (i_addr == SFR_INDIRECT_DATA); // [RQ9]
      o_ind_addr <= cell_reg[SFR_POINTER]; // [RQ9]
      o_ind_wdata <= i_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output read data
  always_comb begin
    o_rdata = rd_ind_reg ? i_ind_rdata : rdata_direct_reg; // [RQ9]
  end

endmodule // sfr_bank0

/* include/sfr_pkg.sv */
/*
  Bank-0 special register map: offsets, field masks, reset values.
  Assumes a single core clock and a 5-bit file address space.
*/
package sfr_pkg;
  // Bank-0 file addresses
  localparam logic [4:0] SFR_INDIRECT_DATA = 5'h00;
  localparam logic [4:0] SFR_TIMER0 = 5'h01;
  localparam logic [4:0] SFR_PCL = 5'h02;
  localparam logic [4:0] SFR_STATUS = 5'h03;
  localparam logic [4:0] SFR_POINTER = 5'h04;
  localparam logic [4:0] SFR_PORT_A = 5'h05;
  localparam logic [4:0] SFR_PORT_B = 5'h06;
  localparam logic [4:0] SFR_PORT_C = 5'h07;
  localparam logic [4:0] SFR_PORT_D = 5'h08;
  localparam logic [4:0] SFR_PORT_E = 5'h09;
  localparam logic [4:0] SFR_PROG_COUNTER_HIGH_LATCH = 5'h0A;
  localparam logic [4:0] SFR_INTERRUPT_CONTROL = 5'h0B;
  localparam logic [4:0] SFR_PIRQ = 5'h0C;
  localparam logic [4:0] SFR_T1L = 5'h0E;
  localparam logic [4:0] SFR_T1H = 5'h0F;
  localparam logic [4:0] SFR_TIMER1_CONTROL = 5'h10;
  localparam logic [4:0] SFR_TIMER2 = 5'h11;
  localparam logic [4:0] SFR_TIMER2_CONTROL = 5'h12;
  localparam logic [4:0] SFR_SERBUF = 5'h13;
  localparam logic [4:0] SFR_SERCON = 5'h14;
  localparam logic [4:0] SFR_CCL = 5'h15;
  localparam logic [4:0] SFR_CCH = 5'h16;
  localparam logic [4:0] SFR_CCCON = 5'h17;
  localparam logic [4:0] SFR_CONV_RESULT = 5'h1E;
  localparam logic [4:0] SFR_CONV_CTRL0 = 5'h1F;
  // Number of storage cells indexed by file address
  localparam int SFR_NUM = 32;
  // Implemented-bit masks
  localparam logic [7:0] SFR_MASK_ALL = 8'hFF;
  localparam logic [7:0] SFR_MASK_6 = 8'h3F;
  localparam logic [7:0] SFR_MASK_5 = 8'h1F;
  localparam logic [7:0] SFR_MASK_7 = 8'h7F;
  localparam logic [7:0] SFR_MASK_PIRQ = 8'hCF;
  // Converter-related bit of the peripheral flags and enables
  localparam logic [7:0] SFR_CONV_BIT = 8'h40;
  // Port A analog-shared bits, read zero on the converter variant
  localparam logic [7:0] SFR_PORT_A_DATA_ANALOG = 8'h2F;
  // Status: power-on and other-reset values; bits 4:3 are conditional
  localparam logic [7:0] SFR_STATUS_POR = 8'h18;
  localparam logic [7:0] SFR_STATUS_KEEP = 8'h07;
  localparam logic [7:0] SFR_STATUS_COND = 8'h18;
  localparam logic [7:0] SFR_ZERO = 8'h00;
  // Reset kinds
  typedef enum logic [1:0] {SFR_RST_NONE, SFR_RST_POR, SFR_RST_OTHER} sfr_rst_t;
endpackage

/* dv/sfr_mem_model.sv */
/*
  Data memory model answering the indirect read path.
  Assumes the bank presents pointer and read pulse from registers.
*/
module sfr_mem_model (
  // Clock
  input wire logic i_mclk,
  // Redirected access
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  output logic [7:0] o_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] noise_reg = 8'h00; // Pattern shown outside reads
  // Off-read cycles change every clock so stale data never passes
  always_ff @(posedge i_mclk) begin
    noise_reg <= noise_reg + 8'h3B;
  end
  assign o_rdata = i_rd ? (i_addr ^ 8'h5A) : noise_reg;
endmodule // sfr_mem_model

/* dv/sfr_bank0_checker.sv */
/*
  Port checker for the bank-0 register file.
  Assumes one clock domain and the asynchronous active-low reset.
*/
module sfr_bank0_checker
  import sfr_pkg::*;
#(
  parameter bit HAS_CONVERTER = 1'b1
) (
  input wire logic i_mclk, i_reset_n, i_por_pulse, i_other_rst_pulse, i_wr, i_rd,
  input wire logic [1:0] i_status_cond,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata, i_ind_rdata, i_port_e_pins,
  input wire logic o_ind_wr, o_ind_rd,
  input wire logic [7:0] o_rdata, o_ind_addr, o_ind_wdata
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  idle_read_zero_a: assert property (!$past(i_rd) && !o_ind_rd |-> o_rdata == 8'h00)
    else $error("read data not zero when idle");
  ind_read_a: assert property (i_rd && i_addr == 5'h00 |=> o_ind_rd && o_rdata == i_ind_rdata)
    else $error("indirect read not redirected");
  ind_write_a: assert property (i_wr && i_addr == 5'h00 |=> o_ind_wr && o_ind_wdata == $past(i_wdata))
    else $error("indirect write not redirected");
  no_redirect_a: assert property (!((i_rd || i_wr) && i_addr == 5'h00) |=> !o_ind_rd && !o_ind_wr)
    else $error("spurious indirect access");
  ind_pointer_a: assert property (i_wr && i_addr == SFR_POINTER ##1 i_rd && i_addr == 5'h00
    |=> o_ind_addr == $past(i_wdata, 2)) else $error("pointer not used");
  unimpl_zero_a: assert property (i_rd && (i_addr == 5'h0D || i_addr inside {[5'h18:5'h1D]})
    |=> o_rdata == 8'h00) else $error("unimplemented read not zero");
  conv_absent_a: assert property (!HAS_CONVERTER && i_rd && i_addr >= 5'h1E |=> o_rdata == 8'h00)
    else $error("converter register visible");
  latch_back_a: assert property (i_wr && i_addr == SFR_PROG_COUNTER_HIGH_LATCH ##1 i_rd && i_addr == SFR_PROG_COUNTER_HIGH_LATCH
    |=> o_rdata == ($past(i_wdata, 2) & 8'h1F)) else $error("latch readback wrong");
  por_status_a: assert property (i_por_pulse ##1 i_rd && i_addr == SFR_STATUS |=> o_rdata == 8'h18)
    else $error("status power-on value wrong");
  other_status_a: assert property (i_other_rst_pulse ##1 i_rd && i_addr == SFR_STATUS
    |=> o_rdata[7:3] == {3'b000, $past(i_status_cond, 2)}) else $error("status reset wrong");
  ind_cov_c: cover property (i_rd && i_addr == 5'h00);
  por_cov_c: cover property (i_por_pulse);
  other_cov_c: cover property (i_other_rst_pulse);
endmodule // sfr_bank0_checker
bind sfr_bank0 sfr_bank0_checker #(.HAS_CONVERTER(HAS_CONVERTER)) u_chk (.i_mclk, .i_reset_n,
  .i_por_pulse, .i_other_rst_pulse, .i_wr, .i_rd, .i_status_cond, .i_addr, .i_wdata,
  .i_ind_rdata, .i_port_e_pins, .o_ind_wr, .o_ind_rd, .o_rdata, .o_ind_addr, .o_ind_wdata);

/* dv/tb_top.sv */
/*
  Testbench for the bank-0 register file, both variants side by side.
  Assumes the data memory model answers the indirect path.
*/
module tb_top
  import sfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_mclk = 0, i_reset_n = 0, i_por_pulse = 0, i_other_rst_pulse = 0, i_wr = 0, i_rd = 0;
  logic [1:0] i_status_cond = 2'h1;
  logic [4:0] i_addr = 5'h00;
  logic [7:0] i_wdata = 8'h00, i_port_e_pins = 8'h3C, mem_rdata, o_rdata, o_ind_addr, o_ind_wdata;
  logic [7:0] o_rdata_cv; // Read data of the converter variant
  logic o_ind_wr, o_ind_rd;
  int n_errors = 0, total_checks = 0;
  logic [4:0] ra[11] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h06, 5'h0A, 5'h0B, 5'h0C, 5'h10, 5'h12, 5'h17};
  logic [7:0] rm[11] = '{8'hBF, 8'hBF, 8'hBF, 8'h3F, 8'hBF, 8'h1F, 8'hBF, 8'h8F, 8'h3F, 8'h3F, 8'h3F};
  logic [4:0] ua[10] = '{5'h0D, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1C, 5'h1D, 5'h1E, 5'h1F, 5'h09};
  sfr_bank0 #(.HAS_CONVERTER(1'b0)) DUT (.i_mclk, .i_reset_n, .i_por_pulse, .i_other_rst_pulse,
    .i_status_cond, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_ind_wr, .o_ind_rd, .o_ind_addr,
    .o_ind_wdata, .i_ind_rdata(mem_rdata), .i_port_e_pins);
  // Converter variant sees the same stimulus; its pointer matches, so memory answers alike
  sfr_bank0 #(.HAS_CONVERTER(1'b1)) DUT_CONV (.i_mclk, .i_reset_n, .i_por_pulse,
    .i_other_rst_pulse, .i_status_cond, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata(o_rdata_cv),
    .o_ind_wr(), .o_ind_rd(), .o_ind_addr(), .o_ind_wdata(), .i_ind_rdata(mem_rdata),
    .i_port_e_pins);
  sfr_mem_model u_mem (.i_mclk, .i_rd(o_ind_rd), .i_addr(o_ind_addr), .o_rdata(mem_rdata));
  initial forever #2 i_mclk = ~i_mclk;
  ////////////////////////////////////////////////////////////////////////////////
  // One-cycle write; the strobe stays up until the next access replaces it
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    i_wr <= 1'b1;
    i_rd <= 1'b0;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_mclk);
  endtask
  // Single compare point: counts and reports any difference
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", what, exp, seen);
    end
  endtask
  // Read, then compare the data standing in the following cycle; cv < 0 means same as exp
  task automatic rc(input logic [4:0] a, input logic [7:0] exp, input int cv = -1);
    i_rd <= 1'b1;
    i_wr <= 1'b0;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    check($sformatf("reg %h", a), o_rdata, exp);
    check($sformatf("conv reg %h", a), o_rdata_cv, (cv < 0) ? exp : 8'(cv));
    @(posedge i_mclk);
  endtask
  // One-cycle reset request of either cause
  task automatic pulse(input bit por);
    if (por) i_por_pulse <= 1'b1;
    else i_other_rst_pulse <= 1'b1;
    @(posedge i_mclk);
    i_por_pulse <= 1'b0;
    i_other_rst_pulse <= 1'b0;
  endtask
  task automatic summarize();
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    @(posedge i_mclk);
    rc(SFR_STATUS, 8'h18);
    foreach (ra[k]) rc(ra[k], 8'h00);
    // Bit 6 kept clear in every write on this variant
    foreach (ra[k]) begin
      wr(ra[k], 8'hBF);
      rc(ra[k], rm[k], (ra[k] == SFR_PORT_A) ? 8'h10 : rm[k]);
    end
    // Bit 1 kept clear so the converter control write stays legal
    foreach (ua[k]) begin
      wr(ua[k], 8'hFD);
      rc(ua[k], (ua[k] == 5'h09) ? 8'h3C : 8'h00, (ua[k] == 5'h1F) ? 8'hFD :
        ((ua[k] == 5'h09) ? 8'h3C : 8'h00));
    end
    wr(5'h00, 8'h77);
    wr(SFR_POINTER, 8'h21);
    rc(5'h00, 8'h7B);
    pulse(1'b0);
    rc(SFR_STATUS, 8'h08);
    rc(SFR_PROG_COUNTER_HIGH_LATCH, 8'h00);
    rc(SFR_TIMER0, 8'hBF);
    rc(SFR_PORT_A, 8'h3F, 8'h10);
    rc(SFR_CONV_CTRL0, 8'h00);
    pulse(1'b1);
    rc(SFR_STATUS, 8'h18);
    rc(SFR_TIMER0, 8'h00);
    summarize();
  end
  // Watchdog well beyond the 118 cycles the tests need
  initial begin
    #100000;
    n_errors++;
    summarize();
  end
endmodule // tb_top
